/* File: common/tgn_regs.svh */
// Purpose: Register offsets, field positions, reset values and timing figures of the tone generator
// Assumes: Byte-wide register port with an 8-bit address
// Notes: Definitions only
`ifndef TGN_REGS_SVH
`define TGN_REGS_SVH

// Register offsets
`define TGN_ADDR_CTRL 8'hA0
`define TGN_ADDR_WAVE 8'hA1
`define TGN_ADDR_A_LO 8'hA2
`define TGN_ADDR_A_HI 8'hA3
`define TGN_ADDR_B_LO 8'hA4
`define TGN_ADDR_B_HI 8'hA5
`define TGN_ADDR_BURST 8'hA6
`define TGN_ADDR_ON 8'hA7
`define TGN_ADDR_OFF 8'hA8

// Field positions
`define TGN_RUN_BIT 7
`define TGN_KEY_EN_BIT 4
`define TGN_KEY_MSB 3
`define TGN_SEL_MSB 1
`define TGN_BURST_MSB 2
`define TGN_PER_MSB 5

// Reset values
`define TGN_RST_A_LO 8'h55
`define TGN_RST_A_HI 8'h15
`define TGN_RST_B_LO 8'h00
`define TGN_RST_B_HI 8'h40
`define TGN_RST_BURST 3'h0
`define TGN_RST_ON 6'h02
`define TGN_RST_OFF 6'h01

// Burst and period encodings
`define TGN_BURST_INF 3'h7
`define TGN_PER_CONT 6'h3F
`define TGN_PER_LIN_MAX 6'h14
`define TGN_PER_STEP_MIN 6'h19
`define TGN_PER_STEP_MAX 6'h3C
`define TGN_PER_STEP_BASE 8'h19
`define TGN_PER_STEP_MUL 8'h05

// Timing: one period unit is 10 ms at a 40 MHz system clock
`define TGN_CLK_HZ 40000000
`define TGN_UNIT_MS 10

// Phase offset that turns sine into cosine, and full positive amplitude for the ramp
`define TGN_QUARTER 16'h4000
`define TGN_FULL_POS 17'sh07FFF

`endif

/* File: common/tgn_pkg.sv */
// Purpose: Shared types of the tone generator
// Assumes: Used with tgn_regs.svh
// Notes: Nothing here is imported; users write tgn_pkg::name
package tgn_pkg;

	// Burst sequencer states, one-hot
	typedef enum logic [3:0] {
		TGN_S_IDLE = 4'h1,
		TGN_S_ON = 4'h2,
		TGN_S_OFF = 4'h4,
		TGN_S_HALT = 4'h8
	} tgn_state_t;

	// Wave selection
	typedef enum logic [1:0] {
		TGN_W_SUM = 2'h0,
		TGN_W_A = 2'h1,
		TGN_W_B = 2'h2,
		TGN_W_RAMP = 2'h3
	} tgn_wave_t;

endpackage : tgn_pkg

/* File: core/tgn_sine.sv */
// Purpose: One sine generator: 16-bit phase accumulator and quarter-wave lookup
// Assumes: tick_smp pulses once per base-rate sample, same clock
// Notes: 64 points per period; cosine taken a quarter turn ahead
`timescale 1ns/1ps
`default_nettype none
`include "tgn_regs.svh"

module tgn_sine (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tick_smp,
	input wire logic phase_clr,
	input wire logic [15:0] step_word,
	output logic [15:0] phase,
	output logic signed [15:0] sin_val,
	output logic signed [15:0] cos_val
);

	logic [15:0] phase_r;
	logic [15:0] phase_nxt;
	logic [16:0] step_p1;

	// Quarter-wave sine, k = 0..16 over 0..pi/2
	function automatic logic [15:0] quarter(input logic [4:0] k);
		case (k)
			5'h00: quarter = 16'h0000;
			5'h01: quarter = 16'h0C8C;
			5'h02: quarter = 16'h18F9;
			5'h03: quarter = 16'h2528;
			5'h04: quarter = 16'h30FC;
			5'h05: quarter = 16'h3C57;
			5'h06: quarter = 16'h471D;
			5'h07: quarter = 16'h5133;
			5'h08: quarter = 16'h5A82;
			5'h09: quarter = 16'h62F2;
			5'h0A: quarter = 16'h6A6E;
			5'h0B: quarter = 16'h70E3;
			5'h0C: quarter = 16'h7642;
			5'h0D: quarter = 16'h7A7D;
			5'h0E: quarter = 16'h7D8A;
			5'h0F: quarter = 16'h7F62;
			default: quarter = 16'h7FFF;
		endcase
	endfunction : quarter

	// Full-wave lookup from the top six phase bits
	function automatic logic [15:0] wave(input logic [15:0] ph);
		logic [4:0] idx;
		logic [15:0] mag;
		idx = {1'b0, ph[13:10]};
		mag = ph[14] ? quarter(5'h10 - idx) : quarter(idx);
		wave = ph[15] ? 16'(-mag) : mag;
	endfunction : wave

	// The stored word is one less than the phase step
	assign step_p1 = {1'b0, step_word} + 17'h00001;
	assign phase_nxt = phase_clr ? 16'h0000 : (tick_smp ? phase_r + step_p1[15:0] : phase_r);
	assign phase = phase_r;
	assign sin_val = wave(phase_r);
	assign cos_val = wave(phase_r + `TGN_QUARTER);

	// Phase accumulator, one step per base-rate sample
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= 16'h0000;
		end else begin
			phase_r <= phase_nxt;
		end
	end

endmodule : tgn_sine
`default_nettype wire

/* File: core/tgn_top.sv */
// Purpose: Dual sine tone generator with keypad tones and timed beep bursts
// Assumes: tick_smp is a one-cycle pulse at the 12 kHz or 11.025 kHz base rate, same clock
// Notes: Notes on behaviour list follows
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tgn_regs.svh"

module tgn_top #(
	parameter int UNIT_CYC = `TGN_CLK_HZ / 1000 * `TGN_UNIT_MS
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic tick_smp,
	input wire logic rate_fam_44k,
	output logic signed [15:0] tone_sample,
	output logic tone_valid,
	output logic tone_active
);

	// Software registers
	logic run_r;
	logic key_en_r;
	logic [3:0] key_r;
	logic [1:0] sel_r;
	logic [7:0] a_lo_r, a_hi_r, b_lo_r, b_hi_r;
	logic [2:0] burst_r;
	logic [5:0] on_r, off_r;
	logic [7:0] rdata_r;
	// Sequencer and output state
	tgn_pkg::tgn_state_t state_r, state_nxt;
	logic [31:0] pre_cnt_r;
	logic [7:0] per_cnt_r;
	logic [5:0] cyc_r;
	logic signed [15:0] sample_r;
	logic valid_r;

	// Keypad row (A) and column (B) step words for both rate families
	function automatic logic [31:0] key_words(input logic [3:0] key, input logic fam);
		logic [1:0] row;
		logic [1:0] col;
		logic [15:0] rw;
		logic [15:0] cw;
		case (key)
			4'h1, 4'h2, 4'h3, 4'hA: row = 2'h0;
			4'h4, 4'h5, 4'h6, 4'hB: row = 2'h1;
			4'h7, 4'h8, 4'h9, 4'hC: row = 2'h2;
			default: row = 2'h3;
		endcase
		case (key)
			4'h1, 4'h4, 4'h7, 4'hE: col = 2'h0;
			4'h2, 4'h5, 4'h8, 4'h0: col = 2'h1;
			4'h3, 4'h6, 4'h9, 4'hF: col = 2'h2;
			default: col = 2'h3;
		endcase
		case ({fam, row})
			3'h0: rw = 16'h0EDE;
			3'h1: rw = 16'h106C;
			3'h2: rw = 16'h122C;
			3'h3: rw = 16'h1412;
			3'h4: rw = 16'h102E;
			3'h5: rw = 16'h11E0;
			3'h6: rw = 16'h13C8;
			default: rw = 16'h15D9;
		endcase
		case ({fam, col})
			3'h0: cw = 16'h19CA;
			3'h1: cw = 16'h1C7F;
			3'h2: cw = 16'h1F81;
			3'h3: cw = 16'h22D5;
			3'h4: cw = 16'h1C12;
			3'h5: cw = 16'h1F05;
			3'h6: cw = 16'h224B;
			default: cw = 16'h25EA;
		endcase
		key_words = {rw, cw};
	endfunction : key_words

	// Period code to count of 10 ms units; reserved codes act as one unit
	function automatic logic [7:0] per_units(input logic [5:0] code);
		if (code != 6'h00 && code <= `TGN_PER_LIN_MAX) begin
			per_units = {2'h0, code};
		end else if (code >= `TGN_PER_STEP_MIN && code <= `TGN_PER_STEP_MAX) begin
			per_units = `TGN_PER_STEP_BASE + 8'({2'h0, code - `TGN_PER_STEP_MIN} * `TGN_PER_STEP_MUL);
		end else begin
			per_units = 8'h01;
		end
	endfunction : per_units

	// Burst code to number of beep cycles
	function automatic logic [5:0] burst_cycles(input logic [2:0] code);
		case (code)
			3'h0: burst_cycles = 6'h01;
			3'h1: burst_cycles = 6'h02;
			3'h2: burst_cycles = 6'h03;
			3'h3: burst_cycles = 6'h04;
			3'h4: burst_cycles = 6'h08;
			3'h5: burst_cycles = 6'h10;
			default: burst_cycles = 6'h20;
		endcase
	endfunction : burst_cycles

	// Register decode
	wire wr_ctrl = reg_wr && reg_addr == `TGN_ADDR_CTRL;
	wire [31:0] kw = key_words(key_r, rate_fam_44k);
	wire [15:0] step_a = key_en_r ? kw[31:16] : {a_hi_r, a_lo_r};
	wire [15:0] step_b = key_en_r ? kw[15:0] : {b_hi_r, b_lo_r};

	// Generators and wave selection
	wire start = state_r == tgn_pkg::TGN_S_IDLE && run_r;
	wire signed [15:0] sin_a, cos_a, sin_b;
	wire [15:0] ph_a, ph_b;
	tgn_sine u_gen_a (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tick_smp(tick_smp),
		.phase_clr(start),
		.step_word(step_a),
		.phase(ph_a),
		.sin_val(sin_a),
		.cos_val(cos_a)
	);
	tgn_sine u_gen_b (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tick_smp(tick_smp),
		.phase_clr(start),
		.step_word(step_b),
		.phase(ph_b),
		.sin_val(sin_b),
		.cos_val()
	);
	// Halving keeps the sum and the ramp inside 16 bits without clipping
	wire signed [16:0] sum_ab = {sin_a[15], sin_a} + {sin_b[15], sin_b};
	wire signed [16:0] ramp = `TGN_FULL_POS - {cos_a[15], cos_a};
	wire signed [15:0] mix = sel_r == tgn_pkg::TGN_W_SUM ? sum_ab[16:1] :
		sel_r == tgn_pkg::TGN_W_A ? sin_a :
		sel_r == tgn_pkg::TGN_W_B ? sin_b : ramp[16:1];
	wire zero_cross = mix == 16'sh0000 || mix[15] != sample_r[15];

	// Period timing
	wire unit_tick = pre_cnt_r == 32'(UNIT_CYC - 1);
	wire on_cont = on_r == `TGN_PER_CONT;
	wire off_cont = off_r == `TGN_PER_CONT;
	wire on_exp = unit_tick && per_cnt_r == per_units(on_r) - 8'h01;
	wire off_exp = unit_tick && per_cnt_r == per_units(off_r) - 8'h01;
	wire burst_last = burst_r != `TGN_BURST_INF && cyc_r + 6'h01 == burst_cycles(burst_r);
	wire playing = state_r == tgn_pkg::TGN_S_ON || state_r == tgn_pkg::TGN_S_HALT;

	// Burst sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			tgn_pkg::TGN_S_IDLE: begin
				if (run_r) state_nxt = tgn_pkg::TGN_S_ON;
			end
			tgn_pkg::TGN_S_ON: begin
				if (on_cont) begin
					if (!run_r) state_nxt = tgn_pkg::TGN_S_HALT;
				end else if (on_exp) begin
					state_nxt = tgn_pkg::TGN_S_OFF;
				end
			end
			tgn_pkg::TGN_S_OFF: begin
				if (off_cont) begin
					if (!run_r) state_nxt = tgn_pkg::TGN_S_IDLE;
				end else if (off_exp) begin
					// With timed periods a cleared run bit ends the burst only here, at the cycle boundary
					state_nxt = (burst_last || !run_r) ? tgn_pkg::TGN_S_IDLE : tgn_pkg::TGN_S_ON;
				end
			end
			tgn_pkg::TGN_S_HALT: begin
				if (tick_smp && zero_cross) state_nxt = tgn_pkg::TGN_S_IDLE;
			end
			default: state_nxt = tgn_pkg::TGN_S_IDLE;
		endcase
	end
	wire done = state_r != tgn_pkg::TGN_S_IDLE && state_nxt == tgn_pkg::TGN_S_IDLE;
	wire new_phase = state_nxt != state_r;

	// Sequencer registers; unit and period counters restart on every state change, the cycle count on start
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= tgn_pkg::TGN_S_IDLE;
			pre_cnt_r <= 32'h0000_0000;
			per_cnt_r <= 8'h00;
			cyc_r <= 6'h00;
		end else begin
			state_r <= state_nxt;
			pre_cnt_r <= (new_phase || unit_tick) ? 32'h0000_0000 : pre_cnt_r + 32'h0000_0001;
			per_cnt_r <= new_phase ? 8'h00 : (unit_tick ? per_cnt_r + 8'h01 : per_cnt_r);
			if (start) cyc_r <= 6'h00;
			else if (state_r == tgn_pkg::TGN_S_OFF && state_nxt == tgn_pkg::TGN_S_ON) cyc_r <= cyc_r + 6'h01;
		end
	end

	// Control register; a software write wins over the self-clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			run_r <= 1'b0;
			key_en_r <= 1'b0;
			key_r <= 4'h0;
		end else if (wr_ctrl) begin
			run_r <= reg_wdata[`TGN_RUN_BIT];
			key_en_r <= reg_wdata[`TGN_KEY_EN_BIT];
			key_r <= reg_wdata[`TGN_KEY_MSB:0];
		end else if (done) begin
			run_r <= 1'b0;
		end
	end

	// Remaining configuration registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sel_r <= tgn_pkg::TGN_W_SUM;
			a_lo_r <= `TGN_RST_A_LO;
			a_hi_r <= `TGN_RST_A_HI;
			b_lo_r <= `TGN_RST_B_LO;
			b_hi_r <= `TGN_RST_B_HI;
			burst_r <= `TGN_RST_BURST;
			on_r <= `TGN_RST_ON;
			off_r <= `TGN_RST_OFF;
		end else if (reg_wr) begin
			case (reg_addr)
				`TGN_ADDR_WAVE: sel_r <= reg_wdata[`TGN_SEL_MSB:0];
				`TGN_ADDR_A_LO: a_lo_r <= reg_wdata;
				`TGN_ADDR_A_HI: a_hi_r <= reg_wdata;
				`TGN_ADDR_B_LO: b_lo_r <= reg_wdata;
				`TGN_ADDR_B_HI: b_hi_r <= reg_wdata;
				`TGN_ADDR_BURST: burst_r <= reg_wdata[`TGN_BURST_MSB:0];
				`TGN_ADDR_ON: on_r <= reg_wdata[`TGN_PER_MSB:0];
				`TGN_ADDR_OFF: off_r <= reg_wdata[`TGN_PER_MSB:0];
				default: ;
			endcase
		end
	end

	// Read mux; reserved bits and unmapped offsets read zero
	wire [7:0] rd_mux = reg_addr == `TGN_ADDR_CTRL ? {run_r, 2'h0, key_en_r, key_r} :
		reg_addr == `TGN_ADDR_WAVE ? {6'h00, sel_r} :
		reg_addr == `TGN_ADDR_A_LO ? a_lo_r :
		reg_addr == `TGN_ADDR_A_HI ? a_hi_r :
		reg_addr == `TGN_ADDR_B_LO ? b_lo_r :
		reg_addr == `TGN_ADDR_B_HI ? b_hi_r :
		reg_addr == `TGN_ADDR_BURST ? {5'h00, burst_r} :
		reg_addr == `TGN_ADDR_ON ? {2'h0, on_r} :
		reg_addr == `TGN_ADDR_OFF ? {2'h0, off_r} : 8'h00;

	// Read data stands one cycle after the strobe only
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// Sample output; silent while idle or in the off period
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sample_r <= 16'sh0000;
			valid_r <= 1'b0;
		end else begin
			valid_r <= tick_smp;
			if (tick_smp) sample_r <= (playing && state_nxt != tgn_pkg::TGN_S_IDLE) ? mix : 16'sh0000;
		end
	end

	assign reg_rdata = rdata_r;
	assign tone_sample = sample_r;
	assign tone_valid = valid_r;
	assign tone_active = state_r != tgn_pkg::TGN_S_IDLE;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	chk_start_runs: assert property (state_r == tgn_pkg::TGN_S_IDLE && run_r |=> state_r == tgn_pkg::TGN_S_ON)
		else $error("run bit did not start the tone");
	chk_run_selfclear: assert property (done && !wr_ctrl |=> !run_r && state_r == tgn_pkg::TGN_S_IDLE)
		else $error("run bit not cleared at end of burst");
	chk_finish_cycle: assert property (state_r == tgn_pkg::TGN_S_OFF && !off_exp && !off_cont
		|=> state_r != tgn_pkg::TGN_S_IDLE)
		else $error("burst left off period early");
	chk_cont_halt: assert property (state_r == tgn_pkg::TGN_S_ON && on_cont && !run_r
		|=> state_r == tgn_pkg::TGN_S_HALT)
		else $error("continuous tone not waiting for zero crossing");
	chk_halt_wait: assert property (state_r == tgn_pkg::TGN_S_HALT && !tick_smp
		|=> state_r == tgn_pkg::TGN_S_HALT)
		else $error("continuous tone stopped off a sample");
	chk_key_source: assert property (key_en_r && tick_smp && !start
		|=> ph_a == $past(ph_a) + $past(kw[31:16]) + 16'h0001 && ph_b == $past(ph_b) + $past(kw[15:0]) + 16'h0001)
		else $error("keypad words not used");
	chk_word_source: assert property (!key_en_r && tick_smp && !start
		|=> ph_a == $past(ph_a) + {$past(a_hi_r), $past(a_lo_r)} + 16'h0001
			&& ph_b == $past(ph_b) + {$past(b_hi_r), $past(b_lo_r)} + 16'h0001)
		else $error("frequency words not used");
	chk_sel_a: assert property (tick_smp && state_r == tgn_pkg::TGN_S_ON && !on_exp
		&& sel_r == tgn_pkg::TGN_W_A |=> tone_sample == $past(sin_a))
		else $error("generator A not routed");
	chk_sel_sum: assert property (tick_smp && state_r == tgn_pkg::TGN_S_ON && !on_exp
		&& sel_r == tgn_pkg::TGN_W_SUM |=> tone_sample == $past(sum_ab[16:1]))
		else $error("sum not routed");
	chk_burst_count: assert property (state_r == tgn_pkg::TGN_S_OFF && state_nxt == tgn_pkg::TGN_S_ON
		|-> burst_r == `TGN_BURST_INF || cyc_r + 6'h01 < burst_cycles(burst_r))
		else $error("burst ran past its count");

endmodule : tgn_top
`default_nettype wire

/* File: bench/tgn_mixer.sv */
// Purpose: Mixer-side model that paces sample ticks and collects tone samples
// Assumes: Same clock as the tone generator
// Notes: Keeps only samples launched while the sequencer was busy
`timescale 1ns/1ps
`default_nettype none

module tgn_mixer #(
	parameter int TICK_DIV = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic signed [15:0] tone_sample,
	input wire logic tone_valid,
	input wire logic tone_active,
	output logic tick_smp
);
	logic [7:0] div_r;
	logic act_r;
	logic signed [15:0] got[$];

	// Sample-rate pulse, one cycle in TICK_DIV
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= 8'h00;
			tick_smp <= 1'b0;
		end else begin
			div_r <= (div_r == 8'(TICK_DIV - 1)) ? 8'h00 : div_r + 8'h01;
			tick_smp <= (div_r == 8'(TICK_DIV - 1));
		end
	end

	// Idle samples dropped, so the queue starts at phase zero
	always @(posedge clk_sys) begin
		if (tick_smp)
			act_r <= tone_active;
		if (tone_valid && act_r)
			got.push_back(tone_sample);
	end
endmodule : tgn_mixer
`default_nettype wire

/* File: bench/tgn_top_bench.sv */
// Purpose: Self-checking bench for the tone generator
// Assumes: Short 10 ms unit so bursts stay at most 1280 cycles
// Notes: Sample checks rely on phases restarting at zero per burst
`timescale 1ns/1ps
`default_nettype none

module tgn_top_bench;
	localparam int U = 20;
	logic clk_sys, rst_n, reg_wr, reg_rd, rate_fam_44k, tick_smp, tone_valid, tone_active;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic signed [15:0] tone_sample;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;

	tgn_top #(.UNIT_CYC(U)) tgn_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tick_smp(tick_smp), .rate_fam_44k(rate_fam_44k), .tone_sample(tone_sample),
		.tone_valid(tone_valid), .tone_active(tone_active));
	tgn_mixer #(.TICK_DIV(4)) tgn_mixer_i (.clk_sys(clk_sys), .rst_n(rst_n), .tone_sample(tone_sample),
		.tone_valid(tone_valid), .tone_active(tone_active), .tick_smp(tick_smp));

	// 40 MHz clock and a cycle count for elapsed times
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) cyc <= cyc + 1;

	task automatic close_out;
		if (num_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Register port: one-cycle strobes, read data one cycle later
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(what, reg_rdata, exp);
	endtask : rchk

	// Bounded wait for the sequencer to go idle
	task automatic wait_idle(output int n);
		n = 0;
		while (tone_active !== 1'b0 && n < 5000) begin
			@(posedge clk_sys);
			#1 n++;
		end
	endtask : wait_idle

	task automatic t_regs;
		logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h55, 8'h15, 8'h00, 8'h40, 8'h00, 8'h02, 8'h01};
		logic [7:0] mk [9] = '{8'h00, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h3F, 8'h3F};
		for (int i = 0; i < 9; i++)
			rchk("reset value", 8'hA0 + 8'(i), rv[i]);
		// Reserved bits must read back as zero
		for (int i = 1; i < 9; i++) begin
			wr(8'hA0 + 8'(i), 8'hFF);
			rchk("readback", 8'hA0 + 8'(i), mk[i]);
		end
		wr(8'hA9, 8'h5A);
		rchk("unmapped", 8'hA9, 8'h00);
	endtask : t_regs

	task automatic t_burst(input logic [2:0] code, input logic [5:0] on, input logic [5:0] off, input int units);
		int n;
		wr(8'hA6, {5'h00, code});
		wr(8'hA7, {2'b00, on});
		wr(8'hA8, {2'b00, off});
		wr(8'hA0, 8'h80);
		@(posedge clk_sys);
		#1 wait_idle(n);
		chk("burst length", n >= units * U - 3 && n <= units * U + 3, 1);
		rchk("run self-clear", 8'hA0, 8'h00);
	endtask : t_burst

	// Stop request in the second beep of an endless burst
	task automatic t_stop_mid;
		int t0;
		int n;
		wr(8'hA6, 8'h07);
		wr(8'hA7, 8'h01);
		wr(8'hA8, 8'h01);
		wr(8'hA0, 8'h80);
		t0 = cyc;
		rchk("run set", 8'hA0, 8'h80);
		repeat (45) @(posedge clk_sys);
		wr(8'hA0, 8'h00);
		wait_idle(n);
		chk("beep finished", cyc - t0 >= 4 * U - 3 && cyc - t0 <= 4 * U + 3, 1);
		rchk("run cleared", 8'hA0, 8'h00);
	endtask : t_stop_mid

	// Continuous tone, take one sample, then stop at a zero crossing
	task automatic t_play(input logic [1:0] wave, input logic [4:0] key, input int idx,
		output logic signed [15:0] s);
		int n;
		wr(8'hA1, {6'h00, wave});
		wr(8'hA7, 8'h3F);
		tgn_mixer_i.got.delete();
		wr(8'hA0, {3'b100, key});
		n = 0;
		while (tgn_mixer_i.got.size() < 4 && n < 1000) begin
			@(posedge clk_sys);
			n++;
		end
		chk("samples seen", tgn_mixer_i.got.size() >= 4, 1);
		s = tgn_mixer_i.got[idx];
		wr(8'hA0, {3'b000, key});
		wait_idle(n);
		chk("zero cross stop", n <= 40, 1);
		repeat (5) @(posedge clk_sys);
		#1 chk("silent after stop", tone_sample, 16'h0000);
	endtask : t_play

	// Endless off period: silent, and left only when run is cleared
	task automatic t_off_cont;
		int n;
		wr(8'hA6, 8'h00);
		wr(8'hA7, 8'h01);
		wr(8'hA8, 8'h3F);
		wr(8'hA0, 8'h80);
		repeat (3 * U) @(posedge clk_sys);
		#1 chk("held in off", tone_active, 1);
		chk("silent in off", tone_sample, 16'h0000);
		wr(8'hA0, 8'h00);
		wait_idle(n);
		chk("off stopped", n <= 3, 1);
	endtask : t_off_cont

	// Quarter-turn step on A, eighth-turn on B
	task automatic t_waves;
		logic signed [15:0] s;
		wr(8'hA2, 8'hFF);
		wr(8'hA3, 8'h3F);
		wr(8'hA4, 8'hFF);
		wr(8'hA5, 8'h1F);
		wr(8'hA8, 8'h01);
		t_play(2'h0, 5'h00, 2, s);
		chk("sum", s, 16'h3FFF);
		t_play(2'h1, 5'h00, 1, s);
		chk("tone a", s, 16'h7FFF);
		t_play(2'h2, 5'h00, 2, s);
		chk("tone b", s, 16'h7FFF);
		t_play(2'h3, 5'h00, 1, s);
		chk("one minus cos", s, 16'h3FFF);
	endtask : t_waves

	// Near-zero words: only the keypad makes audible tones
	task automatic t_keypad;
		logic signed [15:0] s, s1, s2;
		wr(8'hA2, 8'h00);
		wr(8'hA3, 8'h00);
		wr(8'hA4, 8'h00);
		wr(8'hA5, 8'h00);
		t_play(2'h2, 5'h0E, 3, s);
		chk("words used", s, 16'h0000);
		t_play(2'h2, 5'h1E, 3, s1);
		chk("star tone", s1 != 16'sh0000, 1);
		t_play(2'h2, 5'h1F, 3, s2);
		chk("hash differs", s2 != s1, 1);
		rate_fam_44k <= 1'b1;
		t_play(2'h2, 5'h1F, 3, s);
		chk("rate family", s != s2, 1);
	endtask : t_keypad

	// Watchdog: the run needs about 5000 cycles, so allow four times that
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		close_out();
	end

	initial begin
		int nb [7] = '{1, 2, 3, 4, 8, 16, 32};
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		rate_fam_44k = 1'b0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_regs();
		for (int c = 0; c < 7; c++)
			t_burst(3'(c), 6'h01, 6'h01, 2 * nb[c]);
		t_burst(3'h0, 6'h19, 6'h1A, 55);
		t_burst(3'h0, 6'h14, 6'h01, 21);
		t_stop_mid();
		t_off_cont();
		t_waves();
		t_keypad();
		close_out();
	end
endmodule : tgn_top_bench
`default_nettype wire
